/* hw/port_stats_acl_regs.sv */
// Contract
// - Queue 2 limit stays pending until queue 3 limit of same port is written.
// - Each egress limit is seven bits read/write, reset zero, bit 7 reads zero.
// - Thirty counters per port, reached only through control word and data word.
// - Reading a counter through the indirect path clears it.
// - Read trigger set by software clears itself once the value is ready.
// - Value is 36 bits: top nibble in control word, low 32 in data word.
// - Top control bit reports whether the read counter overflowed.
// - Per-port enable, reset zero, admits counters to global flush and freeze.
// - Filter table entries are reached through per-port staging registers.
// - First staging byte holds four-bit first rule index, upper nibble reads zero.
// - Two-bit mode selects none, layer 2, layer 3 or layer 4 filtering.
// - Compare polarity: one matches on equal, zero matches on different.
// - Port-based egress limiting uses queue 0 only; queue 2 and 3 unused.
`timescale 1ns/1ns
module port_stats_acl_regs #(
  parameter int PORT_NUM     = 1,
  parameter int NUM_COUNTERS = 30
) (
  input  wire logic                    clk_sys,
  input  wire logic                    reset_n,
  input  wire logic [15:0]             address,
  input  wire logic                    read,
  input  wire logic                    write,
  input  wire logic [3:0]              byteenable,
  input  wire logic [31:0]             writedata,
  output logic      [31:0]             readdata,
  output logic                         waitrequest,
  output logic                         irq,
  input  wire logic [NUM_COUNTERS-1:0] stat_event,
  input  wire logic                    mib_flush,
  input  wire logic                    mib_freeze,
  input  wire logic                    egress_port_based,
  output logic      [6:0]              egress_q2_limit,
  output logic      [6:0]              egress_q3_limit,
  output logic      [3:0]              filter_first_rule_index,
  output logic      [1:0]              filter_mode,
  output logic      [7:0]              filter_mode_options,
  output logic      [15:0]             filter_mac_upper,
  input  wire logic                    filter_values_equal,
  output logic                         filter_rule_match
);

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  initial begin
    if (PORT_NUM < 1 || PORT_NUM > 6 || NUM_COUNTERS < 1 || NUM_COUNTERS > 256) begin
      $error("port_stats_acl_regs: unsupported parameters");
    end
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic                                 ack;
    logic [31:0]                          rdata;
    logic [6:0]                           q2_pend;
    logic [6:0]                           q2_act;
    logic [6:0]                           q3_act;
    logic                                 go;
    logic                                 flush_en;
    logic [7:0]                           index;
    logic [3:0]                           val_hi;
    logic [31:0]                          val_lo;
    logic                                 ovf;
    logic [3:0]                           rule;
    logic [7:0]                           mode_opt;
    logic [7:0]                           mac5;
    logic [7:0]                           mac4;
    logic [1:0]                           irq_sts;
    logic [1:0]                           irq_mask;
    port_stats_acl_pkg::read_state_type   st;
  } regs_type;

  regs_type s;
  regs_type n;

  logic [11:0]             ofs;
  logic                    hit;
  logic                    wr;
  logic [31:0]             rd_mux;
  logic [35:0]             cnt_val [NUM_COUNTERS];
  logic [NUM_COUNTERS-1:0] cnt_ovf;
  logic [NUM_COUNTERS-1:0] cnt_wrap;
  logic [NUM_COUNTERS-1:0] cnt_clear;
  logic                    sel_ok;
  logic [35:0]             sel_val;
  logic                    sel_ovf;
  logic                    do_flush;
  logic                    do_freeze;
  logic [1:0]              irq_set;

  assign ofs = address[11:0];
  assign hit = address[15:port_stats_acl_pkg::PORT_LSB] == 4'(PORT_NUM);
  assign wr  = write & s.ack & hit;

  // ----------------------------------------
  // Statistics counters
  // ----------------------------------------
  assign do_flush  = s.flush_en & mib_flush;
  assign do_freeze = s.flush_en & mib_freeze;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_COUNTERS; gi++) begin : g_cnt
      assign cnt_clear[gi] = (s.st == port_stats_acl_pkg::ST_FETCH) && (int'(s.index) == gi);
      stat_counter #(
        .WIDTH (port_stats_acl_pkg::COUNT_W)
      ) u_cnt (
        .clk_sys     (clk_sys),
        .reset_n     (reset_n),
        .count_event (stat_event[gi]),
        .read_clear  (cnt_clear[gi]),
        .flush       (do_flush),
        .freeze      (do_freeze),
        .value       (cnt_val[gi]),
        .overflow    (cnt_ovf[gi]),
        .wrap        (cnt_wrap[gi])
      );
    end
  endgenerate

  // Unimplemented index returns zero
  always_comb begin
    sel_ok  = int'(s.index) < NUM_COUNTERS;
    sel_val = '0;
    sel_ovf = 1'b0;
    for (int i = 0; i < NUM_COUNTERS; i++) begin
      if (int'(s.index) == i) begin
        sel_val = cnt_val[i];
        sel_ovf = cnt_ovf[i];
      end
    end
  end

  // ----------------------------------------
  // Read data mux
  // ----------------------------------------
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit) begin
      case (ofs)
        port_stats_acl_pkg::OFS_Q2_LIMIT:   rd_mux[6:0] = s.q2_pend;
        port_stats_acl_pkg::OFS_Q3_LIMIT:   rd_mux[6:0] = s.q3_act;
        port_stats_acl_pkg::OFS_STAT_CTRL: begin
          rd_mux[port_stats_acl_pkg::OVF_BIT]      = s.ovf;
          rd_mux[port_stats_acl_pkg::READ_GO_BIT]  = s.go;
          rd_mux[port_stats_acl_pkg::FLUSH_EN_BIT] = s.flush_en;
          rd_mux[23:16] = s.index;
          rd_mux[3:0]   = s.val_hi;
        end
        port_stats_acl_pkg::OFS_STAT_DATA:  rd_mux = s.val_lo;
        port_stats_acl_pkg::OFS_IRQ_STATUS: rd_mux[1:0] = s.irq_sts;
        port_stats_acl_pkg::OFS_IRQ_MASK:   rd_mux[1:0] = s.irq_mask;
        port_stats_acl_pkg::OFS_RULE_NUM:   rd_mux[3:0] = s.rule;
        port_stats_acl_pkg::OFS_MODE_OPT:   rd_mux[7:0] = s.mode_opt;
        port_stats_acl_pkg::OFS_MAC_BYTE5:  rd_mux[7:0] = s.mac5;
        port_stats_acl_pkg::OFS_MAC_BYTE4:  rd_mux[7:0] = s.mac4;
        default:                            rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    n       = s;
    irq_set = 2'h0;
    n.ack   = (read | write) & ~s.ack;
    if (read & ~s.ack) begin
      n.rdata = rd_mux;
    end
    // Register writes
    if (wr && byteenable[0]) begin
      case (ofs)
        port_stats_acl_pkg::OFS_Q2_LIMIT: n.q2_pend = writedata[6:0];
        port_stats_acl_pkg::OFS_Q3_LIMIT: begin
          n.q3_act = writedata[6:0];
          n.q2_act = s.q2_pend;
        end
        port_stats_acl_pkg::OFS_IRQ_MASK:  n.irq_mask = writedata[1:0];
        port_stats_acl_pkg::OFS_RULE_NUM:  n.rule = writedata[3:0];
        port_stats_acl_pkg::OFS_MODE_OPT:  n.mode_opt = writedata[7:0];
        port_stats_acl_pkg::OFS_MAC_BYTE5: n.mac5 = writedata[7:0];
        port_stats_acl_pkg::OFS_MAC_BYTE4: n.mac4 = writedata[7:0];
        default: begin
        end
      endcase
    end
    if (wr && ofs == port_stats_acl_pkg::OFS_STAT_CTRL) begin
      if (byteenable[2]) begin
        n.index = writedata[23:16];
      end
      if (byteenable[3]) begin
        n.flush_en = writedata[port_stats_acl_pkg::FLUSH_EN_BIT];
        if (writedata[port_stats_acl_pkg::READ_GO_BIT] && !s.go) begin
          n.go = 1'b1;
          n.st = port_stats_acl_pkg::ST_FETCH;
        end
      end
    end
    // Counter fetch
    case (s.st)
      port_stats_acl_pkg::ST_IDLE: begin
      end
      port_stats_acl_pkg::ST_FETCH: begin
        n.val_hi = sel_ok ? sel_val[35:32] : 4'h0;
        n.val_lo = sel_ok ? sel_val[31:0] : 32'h0000_0000;
        n.ovf    = sel_ok & sel_ovf;
        n.go     = 1'b0;
        n.st     = port_stats_acl_pkg::ST_IDLE;
        irq_set[port_stats_acl_pkg::IRQ_READ_DONE] = 1'b1;
      end
      default: n.st = port_stats_acl_pkg::ST_IDLE;
    endcase
    irq_set[port_stats_acl_pkg::IRQ_OVERFLOW] = |cnt_wrap;
    // Write one to clear, set wins
    if (wr && byteenable[0] && ofs == port_stats_acl_pkg::OFS_IRQ_STATUS) begin
      n.irq_sts = s.irq_sts & ~writedata[1:0];
    end
    n.irq_sts = n.irq_sts | irq_set;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s          <= '0;
      s.q2_pend  <= port_stats_acl_pkg::LIMIT_RST;
      s.q2_act   <= port_stats_acl_pkg::LIMIT_RST;
      s.q3_act   <= port_stats_acl_pkg::LIMIT_RST;
      s.index    <= port_stats_acl_pkg::INDEX_RST;
      s.rule     <= port_stats_acl_pkg::RULE_RST;
      s.mode_opt <= port_stats_acl_pkg::BYTE_RST;
      s.mac5     <= port_stats_acl_pkg::BYTE_RST;
      s.mac4     <= port_stats_acl_pkg::BYTE_RST;
      s.st       <= port_stats_acl_pkg::ST_IDLE;
    end else begin
      s <= n;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign readdata    = s.rdata;
  assign waitrequest = (read | write) & ~s.ack;
  assign irq         = |(s.irq_sts & s.irq_mask);

  // Queue 2 and 3 idle under port-based limiting
  assign egress_q2_limit = egress_port_based ? 7'h00 : s.q2_act;
  assign egress_q3_limit = egress_port_based ? 7'h00 : s.q3_act;

  assign filter_first_rule_index = s.rule;
  assign filter_mode             = s.mode_opt[5:4];
  assign filter_mode_options     = s.mode_opt;
  assign filter_mac_upper        = {s.mac5, s.mac4};
  // Mode none never matches
  assign filter_rule_match = (filter_mode != port_stats_acl_pkg::MODE_NONE) &&
    (s.mode_opt[port_stats_acl_pkg::CMP_EQ_BIT] ? filter_values_equal : ~filter_values_equal);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  logic q3_wr;
  assign q3_wr = wr && byteenable[0] && ofs == port_stats_acl_pkg::OFS_Q3_LIMIT;

  property p_q2_held;
    !q3_wr |=> $stable(s.q2_act);
  endproperty
  a_q2_held: assert property (p_q2_held) else $error("queue 2 limit applied early");

  property p_q2_apply;
    q3_wr |=> s.q2_act == $past(s.q2_pend);
  endproperty
  a_q2_apply: assert property (p_q2_apply) else $error("queue 2 limit not applied");

  property p_limit_read;
    (read && !s.ack && hit && ofs == port_stats_acl_pkg::OFS_Q3_LIMIT) |=> readdata[31:7] == 25'h0 &&
      readdata[6:0] == $past(s.q3_act);
  endproperty
  a_limit_read: assert property (p_limit_read) else $error("limit readback wrong");

  property p_bad_index;
    (s.st == port_stats_acl_pkg::ST_FETCH && int'(s.index) >= NUM_COUNTERS) |=> {s.val_hi, s.val_lo} == 36'h0;
  endproperty
  a_bad_index: assert property (p_bad_index) else $error("unused index returned data");

  property p_read_clear;
    (s.st == port_stats_acl_pkg::ST_FETCH && sel_ok && !do_flush) |=> sel_val <= 36'h1;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("counter not cleared by read");

  property p_go_self_clear;
    $rose(s.go) |=> !s.go ##1 s.irq_sts[port_stats_acl_pkg::IRQ_READ_DONE];
  endproperty
  a_go_self_clear: assert property (p_go_self_clear) else $error("trigger did not clear");

  property p_value_split;
    (s.st == port_stats_acl_pkg::ST_FETCH && sel_ok) |=> {s.val_hi, s.val_lo} == $past(sel_val);
  endproperty
  a_value_split: assert property (p_value_split) else $error("value split wrong");

  property p_ovf_flag;
    (s.st == port_stats_acl_pkg::ST_FETCH) |=> s.ovf == $past(sel_ok & sel_ovf);
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag wrong");

  property p_rule_read;
    (read && !s.ack && hit && ofs == port_stats_acl_pkg::OFS_RULE_NUM) |=> readdata[31:4] == 28'h0;
  endproperty
  a_rule_read: assert property (p_rule_read) else $error("rule byte upper bits set");

  property p_polarity;
    (filter_mode != port_stats_acl_pkg::MODE_NONE && !s.mode_opt[0]) |-> filter_rule_match == !filter_values_equal;
  endproperty
  a_polarity: assert property (p_polarity) else $error("compare polarity wrong");

  property p_port_based;
    egress_port_based |-> egress_q2_limit == 7'h00 && egress_q3_limit == 7'h00;
  endproperty
  a_port_based: assert property (p_port_based) else $error("queue limits used port-based");

  property p_wait_bound;
    (read || write) |-> ##[0:1] !waitrequest;
  endproperty
  a_wait_bound: assert property (p_wait_bound) else $error("waitrequest too long");

  c_fetch: cover property ($rose(s.go) ##1 $fell(s.go));
  c_q2_apply: cover property (q3_wr ##1 $changed(s.q2_act));
  c_irq: cover property ($rose(irq));
  c_flush: cover property (do_flush);

endmodule : port_stats_acl_regs

/* pkg/port_stats_acl_pkg.sv */
package port_stats_acl_pkg;

  // ----------------------------------------
  // Register offsets within one port space
  // ----------------------------------------
  localparam logic [11:0] OFS_Q2_LIMIT   = 12'h422;
  localparam logic [11:0] OFS_Q3_LIMIT   = 12'h423;
  localparam logic [11:0] OFS_STAT_CTRL  = 12'h500;
  localparam logic [11:0] OFS_STAT_DATA  = 12'h504;
  localparam logic [11:0] OFS_IRQ_STATUS = 12'h508;
  localparam logic [11:0] OFS_IRQ_MASK   = 12'h509;
  localparam logic [11:0] OFS_RULE_NUM   = 12'h600;
  localparam logic [11:0] OFS_MODE_OPT   = 12'h601;
  localparam logic [11:0] OFS_MAC_BYTE5  = 12'h602;
  localparam logic [11:0] OFS_MAC_BYTE4  = 12'h603;

  // ----------------------------------------
  // Field positions and widths
  // ----------------------------------------
  localparam int PORT_LSB     = 12;
  localparam int LIMIT_W      = 7;
  localparam int RULE_W       = 4;
  localparam int COUNT_W      = 36;
  localparam int OVF_BIT      = 31;
  localparam int READ_GO_BIT  = 25;
  localparam int FLUSH_EN_BIT = 24;
  localparam int INDEX_LSB    = 16;
  localparam int INDEX_W      = 8;
  localparam int VAL_HI_W     = 4;
  localparam int MODE_LSB     = 4;
  localparam int CMP_EQ_BIT   = 0;
  localparam int IRQ_W        = 2;
  localparam int IRQ_READ_DONE = 0;
  localparam int IRQ_OVERFLOW  = 1;

  // ----------------------------------------
  // Values after reset
  // ----------------------------------------
  localparam logic [6:0] LIMIT_RST = 7'h00;
  localparam logic [3:0] RULE_RST  = 4'h0;
  localparam logic [7:0] BYTE_RST  = 8'h00;
  localparam logic [7:0] INDEX_RST = 8'h00;

  // ----------------------------------------
  // Filter modes and counter read states
  // ----------------------------------------
  localparam logic [1:0] MODE_NONE = 2'h0;
  localparam logic [1:0] MODE_L2   = 2'h1;
  localparam logic [1:0] MODE_L3   = 2'h2;
  localparam logic [1:0] MODE_L4   = 2'h3;

  typedef enum logic {
    ST_IDLE  = 1'b0,
    ST_FETCH = 1'b1
  } read_state_type;

endpackage : port_stats_acl_pkg

/* hw/stat_counter.sv */
`timescale 1ns/1ns
module stat_counter #(
  parameter int WIDTH = 36
) (
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  input  wire logic             count_event,
  input  wire logic             read_clear,
  input  wire logic             flush,
  input  wire logic             freeze,
  output logic      [WIDTH-1:0] value,
  output logic                  overflow,
  output logic                  wrap
);

  typedef struct packed {
    logic [WIDTH-1:0] cnt;
    logic             ovf;
  } cnt_type;

  cnt_type s;
  cnt_type n;
  logic    bump;

  // ----------------------------------------
  // Count, clear on read, flush
  // ----------------------------------------
  always_comb begin
    n    = s;
    bump = count_event & ~freeze;
    wrap = bump & (&s.cnt);
    if (flush) begin
      n.cnt = '0;
      n.ovf = 1'b0;
    end else if (read_clear) begin
      // Event in the clearing cycle is kept
      n.cnt = bump ? WIDTH'(1) : '0;
      n.ovf = 1'b0;
    end else if (bump) begin
      n.cnt = s.cnt + WIDTH'(1);
      n.ovf = s.ovf | wrap;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign value    = s.cnt;
  assign overflow = s.ovf;

endmodule : stat_counter

/* tb/port_stats_acl_regs_tb_top.sv */
`timescale 1ns/1ns
module port_stats_acl_regs_tb_top;

  // ----------------------------------------
  // Signals and design instance
  // ----------------------------------------
  localparam logic [3:0]  PN         = 4'h3;
  localparam logic [11:0] RST_OFS[8] = '{12'h422, 12'h423, 12'h500, 12'h504,
                                         12'h600, 12'h601, 12'h602, 12'h603};
  logic        clk_sys             = 1'b0;
  logic        reset_n             = 1'b0;
  logic [15:0] address             = 16'h0000;
  logic        read                = 1'b0;
  logic        write               = 1'b0;
  logic [3:0]  byteenable          = 4'h0;
  logic [31:0] writedata           = 32'h0000_0000;
  logic [29:0] stat_event          = 30'h0000_0000;
  logic        mib_flush           = 1'b0;
  logic        mib_freeze          = 1'b0;
  logic        egress_port_based   = 1'b0;
  logic        filter_values_equal = 1'b0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        irq;
  logic [6:0]  egress_q2_limit;
  logic [6:0]  egress_q3_limit;
  logic [3:0]  filter_first_rule_index;
  logic [1:0]  filter_mode;
  logic [7:0]  filter_mode_options;
  logic [15:0] filter_mac_upper;
  logic        filter_rule_match;
  logic [31:0] rd;
  logic        flush_en            = 1'b0;
  int          errors              = 0;
  int          n_tests             = 0;
  int          cycles              = 0;

  port_stats_acl_regs #(.PORT_NUM(3), .NUM_COUNTERS(30)) dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .irq(irq), .stat_event(stat_event), .mib_flush(mib_flush), .mib_freeze(mib_freeze),
    .egress_port_based(egress_port_based), .egress_q2_limit(egress_q2_limit),
    .egress_q3_limit(egress_q3_limit), .filter_first_rule_index(filter_first_rule_index),
    .filter_mode(filter_mode), .filter_mode_options(filter_mode_options),
    .filter_mac_upper(filter_mac_upper), .filter_values_equal(filter_values_equal),
    .filter_rule_match(filter_rule_match));

  always #2 clk_sys = ~clk_sys;

  // ----------------------------------------
  // Verdict, timeout and comparisons
  // ----------------------------------------
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("wrong value at %0t: run did not finish", $time);
      report_and_stop();
    end
  end

  task automatic check_reg(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check_reg

  // Pins sampled mid-cycle, then back on the rising edge
  task automatic check_pin(input int which, input logic [15:0] exp, input string what);
    logic [15:0] got;
    @(negedge clk_sys);
    case (which)
      0: got = {9'h000, egress_q2_limit};
      1: got = {9'h000, egress_q3_limit};
      2: got = {12'h000, filter_first_rule_index};
      3: got = {14'h0000, filter_mode};
      4: got = filter_mac_upper;
      5: got = {15'h0000, filter_rule_match};
      7: got = {8'h00, filter_mode_options};
      default: got = {15'h0000, irq};
    endcase
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
    @(posedge clk_sys);
  endtask : check_pin

  // ----------------------------------------
  // Bus cycles
  // ----------------------------------------
  task automatic bus(input logic wr, input logic [15:0] adr, input logic [31:0] wd,
                     input logic [3:0] be, output logic [31:0] data);
    address    <= adr;
    write      <= wr;
    read       <= ~wr;
    writedata  <= wd;
    byteenable <= be;
    @(posedge clk_sys);
    while (waitrequest !== 1'b0) @(posedge clk_sys);
    data = readdata;
    write <= 1'b0;
    read  <= 1'b0;
    @(posedge clk_sys);
  endtask : bus

  task automatic wreg(input logic [11:0] ofs, input logic [31:0] wd, input logic [3:0] be);
    bus(1'b1, {PN, ofs}, wd, be, rd);
  endtask : wreg

  task automatic rreg(input logic [11:0] ofs, input logic [31:0] exp, input string what);
    bus(1'b0, {PN, ofs}, 32'h0000_0000, 4'hF, rd);
    check_reg(rd, exp, what);
  endtask : rreg

  task automatic events(input int idx, input int cnt);
    stat_event <= 30'h0000_0001 << idx;
    repeat (cnt) @(posedge clk_sys);
    stat_event <= 30'h0000_0000;
    @(posedge clk_sys);
  endtask : events

  task automatic pulse_flush();
    mib_flush <= 1'b1;
    @(posedge clk_sys);
    mib_flush <= 1'b0;
    @(posedge clk_sys);
  endtask : pulse_flush

  // Start a counter read, poll until the trigger clears, check both words
  task automatic fetch(input logic [7:0] idx, input logic [35:0] exp, input string what);
    int n;
    wreg(12'h500, {6'h00, 1'b1, flush_en, idx, 16'h0000}, 4'hC);
    n = 0;
    do begin
      bus(1'b0, {PN, 12'h500}, 32'h0000_0000, 4'hF, rd);
      n++;
    end while (rd[25] === 1'b1 && n < 20);
    check_reg(rd, {7'h00, flush_en, idx, 12'h000, exp[35:32]}, what);
    rreg(12'h504, exp[31:0], what);
  endtask : fetch

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    int m;
    int p;
    int e;
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    foreach (RST_OFS[i]) rreg(RST_OFS[i], 32'h0000_0000, "reset value");
    $display("test reset values done");

    wreg(12'h422, 32'h0000_00FF, 4'h1);
    rreg(12'h422, 32'h0000_007F, "q2 pending readback");
    check_pin(0, 16'h0000, "q2 held pending");
    wreg(12'h423, 32'h0000_0085, 4'h1);
    check_pin(0, 16'h007F, "q2 applied by q3 write");
    check_pin(1, 16'h0005, "q3 limit");
    rreg(12'h423, 32'h0000_0005, "q3 readback");
    wreg(12'h422, 32'h0000_0011, 4'h1);
    check_pin(0, 16'h007F, "old q2 kept");
    egress_port_based <= 1'b1;
    check_pin(0, 16'h0000, "q2 unused port based");
    check_pin(1, 16'h0000, "q3 unused port based");
    egress_port_based <= 1'b0;
    $display("test egress limits done");

    wreg(12'h600, 32'h0000_00FF, 4'h1);
    rreg(12'h600, 32'h0000_000F, "rule index readback");
    check_pin(2, 16'h000F, "rule index pin");
    wreg(12'h602, 32'h0000_00A5, 4'h1);
    wreg(12'h603, 32'h0000_003C, 4'h1);
    rreg(12'h602, 32'h0000_00A5, "mac byte5");
    check_pin(4, 16'hA53C, "mac upper pin");
    for (m = 0; m < 4; m++) begin
      for (p = 0; p < 2; p++) begin
        wreg(12'h601, {24'h00_0000, 2'b11, m[1:0], 3'b010, p[0]}, 4'h1);
        rreg(12'h601, {24'h00_0000, 2'b11, m[1:0], 3'b010, p[0]}, "mode byte");
        check_pin(3, 16'(m), "filter mode");
        check_pin(7, {8'h00, 2'b11, m[1:0], 3'b010, p[0]}, "mode options pin");
        for (e = 0; e < 2; e++) begin
          filter_values_equal <= e[0];
          check_pin(5, 16'((m != 0) && (p != 0 ? e != 0 : e == 0)), "rule match");
        end
      end
    end
    $display("test filter staging done");

    events(3, 5);
    fetch(8'h03, 36'h0_0000_0005, "counter 3");
    fetch(8'h03, 36'h0_0000_0000, "counter 3 after read");
    events(29, 2);
    fetch(8'h1D, 36'h0_0000_0002, "counter 29");
    events(0, 1);
    fetch(8'h1E, 36'h0_0000_0000, "index beyond counters");
    wreg(12'h504, 32'hFFFF_FFFF, 4'hF);
    rreg(12'h504, 32'h0000_0000, "data word read only");
    events(1, 4);
    pulse_flush();
    fetch(8'h01, 36'h0_0000_0004, "flush ignored when disabled");
    flush_en = 1'b1;
    wreg(12'h500, 32'h0100_0000, 4'h8);
    events(1, 4);
    pulse_flush();
    fetch(8'h01, 36'h0_0000_0000, "flush when enabled");
    mib_freeze <= 1'b1;
    events(2, 3);
    mib_freeze <= 1'b0;
    fetch(8'h02, 36'h0_0000_0000, "freeze when enabled");
    flush_en = 1'b0;
    wreg(12'h500, 32'h0000_0000, 4'h8);
    mib_freeze <= 1'b1;
    events(2, 3);
    mib_freeze <= 1'b0;
    fetch(8'h02, 36'h0_0000_0003, "freeze ignored when disabled");
    $display("test statistics counters done");

    rreg(12'h508, 32'h0000_0001, "read done status");
    check_pin(6, 16'h0000, "irq masked");
    wreg(12'h509, 32'h0000_0001, 4'h1);
    check_pin(6, 16'h0001, "irq unmasked");
    wreg(12'h508, 32'h0000_0001, 4'h1);
    check_pin(6, 16'h0000, "irq after clear");
    rreg(12'h508, 32'h0000_0000, "status after clear");
    $display("test interrupt done");

    wreg(12'h7FF, 32'hFFFF_FFFF, 4'hF);
    rreg(12'h7FF, 32'h0000_0000, "unmapped offset");
    bus(1'b1, 16'h1422, 32'h0000_0022, 4'h1, rd);
    rreg(12'h422, 32'h0000_0011, "other port write ignored");
    bus(1'b0, 16'h1600, 32'h0000_0000, 4'hF, rd);
    check_reg(rd, 32'h0000_0000, "other port read");
    $display("test refused accesses done");
    report_and_stop();
  end

endmodule : port_stats_acl_regs_tb_top
